// ---- hdl/lpm_defines.svh ----
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH
// Clock rate, wake and restore times and deep sleep limit, in their own units
`define LPM_CLK_HZ          10000000
`define LPM_DS_WAKE_US      3000
`define LPM_HIB_WAKE_MS     50
`define LPM_SHD_WAKE_MS     1100
`define LPM_RESTORE_MS      8000
`define LPM_DS_MAX_S        22
// Cycle counts derived from the rate, and a fixed idle count
`define LPM_DS_WAKE_CYC     ((`LPM_CLK_HZ / 1000000) * `LPM_DS_WAKE_US)
`define LPM_HIB_WAKE_CYC    ((`LPM_CLK_HZ / 1000) * `LPM_HIB_WAKE_MS)
`define LPM_SHD_WAKE_CYC    ((`LPM_CLK_HZ / 1000) * `LPM_SHD_WAKE_MS)
`define LPM_RESTORE_CYC     ((`LPM_CLK_HZ / 1000) * `LPM_RESTORE_MS)
`define LPM_DS_MAX_CYC      (`LPM_CLK_HZ * `LPM_DS_MAX_S)
`define LPM_IDLE_CYC        1000
// Boot option code and restore mode encodings
`define LPM_BOOT_RESTORE    3'h6
`define LPM_RST_NONE        2'h0
`define LPM_RST_PARAMS      2'h1
`define LPM_RST_IMAGE       2'h2
`endif

// ---- hdl/lpm_pkg.sv ----
package lpm_pkg;
  // Power sequencer states, one-hot
  typedef enum logic [7:0] {
    LPM_BOOT    = 8'h01,
    LPM_RUN     = 8'h02,
    LPM_DSLEEP  = 8'h04,
    LPM_DSWAKE  = 8'h08,
    LPM_HIB     = 8'h10,
    LPM_SHUT    = 8'h20,
    LPM_WAKE    = 8'h40,
    LPM_RESTORE = 8'h80
  } lpm_state_e;
  typedef logic [1:0] lpm_rmode_t;
endpackage

// ---- hdl/lpm_sync.sv ----
`timescale 1ns/10ps
// Two-flop synchroniser for pin inputs
module lpm_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q; // First stage, read only by the second
  logic [W-1:0] s2_q; // Second stage
  // Register both stages
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule

// ---- hdl/lpm_seq.sv ----
`timescale 1ns/10ps
`include "lpm_defines.svh"
// How it works
// - Deep sleep entered and left without handshake
// - Deep sleep wake within 3 ms
// - Context held through deep sleep
// - Deep sleep period up to 22 s
// - Hibernate gates logic, RTC keeps counting
// - Hibernate request wakes in about 50 ms
// - Shutdown stops RTC, wakes in 1.1 s
// - Three restore modes: none, params, image
// - Boot code 110 at reset release restores
// - Restore resumes after power loss
// - Restore takes about 8 s
// - Factory sector access always refused
module lpm_seq #(
  parameter int unsigned IDLE_CYC    = `LPM_IDLE_CYC,
  parameter int unsigned DS_WAKE_CYC = `LPM_DS_WAKE_CYC,
  parameter int unsigned DS_MAX_CYC  = `LPM_DS_MAX_CYC,
  parameter int unsigned HIB_CYC     = `LPM_HIB_WAKE_CYC,
  parameter int unsigned SHD_CYC     = `LPM_SHD_WAKE_CYC,
  parameter int unsigned RESTORE_CYC = `LPM_RESTORE_CYC
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               chip_reset_n,
  input  wire logic [2:0]         boot_option_pins,
  input  wire logic               hibernate_request_n,
  input  wire logic               host_cmd,
  input  wire logic               activity,
  input  wire logic               long_sleep_en,
  input  wire logic [31:0]        sleep_cycles,
  input  wire lpm_pkg::lpm_rmode_t restore_mode,
  input  wire logic               hib_enter,
  input  wire logic               shut_enter,
  input  wire logic               main_power_ok,
  input  wire logic               restore_pending_nv,
  input  wire logic               nvm_req,
  input  wire logic               nvm_factory_sel,
  output logic                    nvm_grant,
  output logic                    nvm_refused,
  output logic                    restore_pending_set,
  output logic                    restore_params,
  output logic                    restore_image,
  output logic                    logic_power_on,
  output logic                    context_retain,
  output logic                    rtc_run,
  output logic [31:0]             rtc_count,
  output logic                    ready,
  output logic [7:0]              state
);
  import lpm_pkg::*;

  // Refuse counts that the timers cannot serve
  if (IDLE_CYC < 1 || DS_WAKE_CYC < 1 || HIB_CYC < 1 ||
      SHD_CYC < 1 || RESTORE_CYC < 1) begin : g_bad_count
    $error("lpm_seq: counts must be at least one");
  end
  // Wake budget may not exceed the deep sleep wake limit
  if (DS_WAKE_CYC > `LPM_DS_WAKE_CYC) begin : g_bad_wake
    $error("lpm_seq: deep sleep wake exceeds 3 ms");
  end
  // Short sleep limit is a fraction of the long one and must not reach zero
  if (DS_MAX_CYC < `LPM_DS_MAX_S) begin : g_bad_max
    $error("lpm_seq: deep sleep limit too short");
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // The request travels inverted, so a cleared synchroniser reads as an idle line
  // and no false wake edge follows reset
  logic [4:0] pin_s; // Synchronised reset, boot pins, inverted hibernate request
  lpm_sync #(.W(5)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({chip_reset_n, boot_option_pins, ~hibernate_request_n}),
    .dout (pin_s)
  );
  logic       crst_n_s; // Chip reset, synchronised
  logic [2:0] bopt_s;   // Boot option pins, synchronised
  logic       hreq_n_s; // Hibernate request, synchronised
  assign crst_n_s = pin_s[4];
  assign bopt_s   = pin_s[3:1];
  assign hreq_n_s = ~pin_s[0];

  // ==========================================================
  // Sequencer state
  // ==========================================================
  lpm_state_e  st_q, st_d;   // Current state
  logic [31:0] cnt_q, cnt_d; // Shared timer
  logic        crst_q, crst_d; // Last chip reset level
  logic        hreq_q, hreq_d; // Last hibernate request level
  logic [1:0]  rmode_q, rmode_d; // Restore mode latched at boot
  logic        pend_q, pend_d; // Restore in progress
  logic        ctx_q, ctx_d;   // Context retained flag
  logic [31:0] rtc_q, rtc_d;   // RTC counter, held at zero in shutdown
  logic [31:0] slp;            // Deep sleep length, clipped

  // Clip a requested sleep length to the allowed maximum
  function automatic logic [31:0] clip_sleep(input logic [31:0] req, input logic lng);
    logic [31:0] lim;
    lim = lng ? 32'(DS_MAX_CYC) : 32'(DS_MAX_CYC / `LPM_DS_MAX_S);
    clip_sleep = (req == 32'h0) ? 32'h1 : ((req > lim) ? lim : req);
  endfunction

  // Next state and timers
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    crst_d  = crst_n_s;
    hreq_d  = hreq_n_s;
    rmode_d = rmode_q;
    pend_d  = pend_q;
    ctx_d   = ctx_q;
    rtc_d   = rtc_q;
    slp     = clip_sleep(sleep_cycles, long_sleep_en);
    // RTC counts in every state but shutdown
    if (st_q != LPM_SHUT)
      rtc_d = rtc_q + 32'h1;
    else
      rtc_d = 32'h0;
    if (!crst_n_s) begin
      // Chip held in reset
      st_d  = LPM_BOOT;
      cnt_d = 32'h0;
      ctx_d = 1'b0;
    end else if (!crst_q && main_power_ok) begin
      // Rising edge of chip reset samples the boot pins
      if (bopt_s == `LPM_BOOT_RESTORE || restore_pending_nv) begin
        st_d    = LPM_RESTORE;
        rmode_d = restore_mode;
        pend_d  = 1'b1;
      end else begin
        st_d    = LPM_RUN;
        rmode_d = `LPM_RST_NONE;
        pend_d  = 1'b0; // Drop a flag left by a cut restore
      end
      cnt_d = 32'h0;
    end else begin
      case (st_q)
        LPM_BOOT: begin
          cnt_d = 32'h0;
        end
        LPM_RUN: begin
          if (shut_enter) begin
            st_d  = LPM_SHUT;
            ctx_d = 1'b0;
            cnt_d = 32'h0;
          end else if (hib_enter) begin
            st_d  = LPM_HIB;
            ctx_d = 1'b0;
            cnt_d = 32'h0;
          end else if (activity || host_cmd) begin
            cnt_d = 32'h0;
          end else if (cnt_q >= 32'(IDLE_CYC - 1)) begin
            st_d  = LPM_DSLEEP;
            ctx_d = 1'b1;
            cnt_d = 32'h0;
          end else begin
            cnt_d = cnt_q + 32'h1;
          end
        end
        LPM_DSLEEP: begin
          if (host_cmd || cnt_q >= slp - 32'h1) begin
            st_d  = LPM_DSWAKE;
            cnt_d = 32'h0;
          end else begin
            cnt_d = cnt_q + 32'h1;
          end
        end
        LPM_DSWAKE, LPM_WAKE: begin
          if (cnt_q == 32'h0) begin
            st_d = LPM_RUN;
          end else begin
            cnt_d = cnt_q - 32'h1;
          end
        end
        LPM_HIB: begin
          // Falling edge of the active-low request wakes the chip
          if (hreq_q && !hreq_n_s) begin
            st_d  = LPM_WAKE;
            cnt_d = 32'(HIB_CYC - 1);
          end
        end
        LPM_SHUT: begin
          if (hreq_q && !hreq_n_s) begin
            st_d  = LPM_WAKE;
            cnt_d = 32'(SHD_CYC - 1);
          end
        end
        LPM_RESTORE: begin
          if (cnt_q >= 32'(RESTORE_CYC - 1)) begin
            st_d   = LPM_RUN;
            pend_d = 1'b0;
            cnt_d  = 32'h0;
          end else begin
            cnt_d = cnt_q + 32'h1;
          end
        end
        default: begin
          st_d  = LPM_BOOT;
          cnt_d = 32'h0;
        end
      endcase
    end
    // Deep sleep wake counts down from the wake budget
    if (st_q == LPM_DSLEEP && st_d == LPM_DSWAKE)
      cnt_d = 32'(DS_WAKE_CYC - 1);
  end

  // Register the sequencer state
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q    <= LPM_BOOT;
      cnt_q   <= 32'h0;
      crst_q  <= 1'b0;
      hreq_q  <= 1'b1;
      rmode_q <= 2'h0;
      pend_q  <= 1'b0;
      ctx_q   <= 1'b0;
      rtc_q   <= 32'h0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      crst_q  <= crst_d;
      hreq_q  <= hreq_d;
      rmode_q <= rmode_d;
      pend_q  <= pend_d;
      ctx_q   <= ctx_d;
      rtc_q   <= rtc_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic rsting; // Restore underway
  assign rsting              = (st_q == LPM_RESTORE);
  assign restore_pending_set = pend_q;
  assign restore_params      = rsting && (rmode_q != `LPM_RST_NONE);
  assign restore_image       = rsting && (rmode_q == `LPM_RST_IMAGE);
  assign logic_power_on      = !(st_q == LPM_HIB || st_q == LPM_SHUT);
  assign context_retain      = ctx_q;
  assign rtc_run             = (st_q != LPM_SHUT);
  assign rtc_count           = rtc_q;
  assign ready               = (st_q == LPM_RUN);
  assign state               = st_q;
  assign nvm_refused         = nvm_req && nvm_factory_sel;
  assign nvm_grant           = nvm_req && !nvm_factory_sel && (st_q == LPM_RUN);

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence s_hib_wake;
    (st_q == LPM_HIB) ##1 (st_q == LPM_WAKE);
  endsequence
  a_factory_refused: assert property (@(posedge mclk) disable iff (rst)
    nvm_req && nvm_factory_sel |-> !nvm_grant && nvm_refused)
    else $error("factory sector access granted");
  a_shut_rtc_stop: assert property (@(posedge mclk) disable iff (rst)
    (st_q == LPM_SHUT) |=> (rtc_q == 32'h0) || (st_q != LPM_SHUT))
    else $error("rtc ran in shutdown");
  a_hib_rtc_run: assert property (@(posedge mclk) disable iff (rst)
    (st_q == LPM_HIB) && crst_n_s |=> rtc_q == $past(rtc_q) + 32'h1)
    else $error("rtc stalled in hibernate");
  a_hib_gated: assert property (@(posedge mclk) disable iff (rst)
    (st_q == LPM_HIB) |-> !logic_power_on && rtc_run)
    else $error("logic powered in hibernate");
  a_hib_wake_len: assert property (@(posedge mclk) disable iff (rst)
    s_hib_wake |-> cnt_q == 32'(HIB_CYC - 1))
    else $error("hibernate wake time wrong");
  a_ds_ctx_kept: assert property (@(posedge mclk) disable iff (rst)
    (st_q == LPM_DSLEEP) |-> context_retain && logic_power_on)
    else $error("context lost in deep sleep");
  a_ds_wake_len: assert property (@(posedge mclk) disable iff (rst)
    $rose(st_q == LPM_DSWAKE) |-> cnt_q == 32'(DS_WAKE_CYC - 1))
    else $error("deep sleep wake budget wrong");
  a_restore_code: assert property (@(posedge mclk) disable iff (rst)
    crst_n_s && !crst_q && main_power_ok && bopt_s == `LPM_BOOT_RESTORE
    |=> st_q == LPM_RESTORE)
    else $error("restore code ignored");
  a_normal_boot: assert property (@(posedge mclk) disable iff (rst)
    crst_n_s && !crst_q && main_power_ok && bopt_s != `LPM_BOOT_RESTORE
    && !restore_pending_nv |=> st_q == LPM_RUN)
    else $error("normal boot failed");
  a_idle_sleep: assert property (@(posedge mclk) disable iff (rst)
    (st_q == LPM_DSLEEP) && !$past(st_q == LPM_DSLEEP) |-> $past(st_q) == LPM_RUN)
    else $error("deep sleep entered from wrong state");
endmodule

// ---- verification/lpm_host.sv ----
`timescale 1ns/10ps
// ==========
// Host model: owns the reset, boot option and hibernate request pins
module lpm_host (
  input  wire logic       mclk,
  output logic            chip_reset_n,
  output logic [2:0]      boot_option_pins,
  output logic            hibernate_request_n
);
  // Power-up levels: reset held low keeps the device in boot
  initial begin
    chip_reset_n        = 1'b0;
    boot_option_pins    = 3'h0;
    hibernate_request_n = 1'b1;
  end
  // Straps stay put while reset is low and after it rises
  task automatic boot(input logic [2:0] code);
    @(negedge mclk);
    chip_reset_n     = 1'b0;
    boot_option_pins = code;
    repeat (4) @(negedge mclk);
    chip_reset_n = 1'b1;
  endtask
  // Request low for four cycles, long enough to pass the synchroniser
  task automatic hib_wake();
    @(negedge mclk);
    hibernate_request_n = 1'b0;
    repeat (4) @(negedge mclk);
    hibernate_request_n = 1'b1;
  endtask
endmodule

// ---- verification/tb_low_power_mode_and_restore_seq.sv ----
`timescale 1ns/10ps
// ==========
// Bench for the power mode and restore sequencer
module tb_low_power_mode_and_restore_seq;
  import lpm_pkg::*;
  // Shortened counts handed to the design
  localparam int IDLE = 4, DSW = 3, DSMAX = 44, HIB = 5, SHD = 7, RCYC = 10;
  logic        mclk, rst, chip_reset_n, hibernate_request_n;
  logic [2:0]  boot_option_pins;
  logic        host_cmd, activity, long_sleep_en, hib_enter, shut_enter;
  logic        main_power_ok, restore_pending_nv, nvm_req, nvm_factory_sel;
  logic [31:0] sleep_cycles, rtc_count;
  lpm_rmode_t  restore_mode;
  logic        nvm_grant, nvm_refused, restore_pending_set, restore_params;
  logic        restore_image, logic_power_on, context_retain, rtc_run, ready;
  logic [7:0]  state;
  int          errors, tests_run;

  lpm_seq #(.IDLE_CYC(IDLE), .DS_WAKE_CYC(DSW), .DS_MAX_CYC(DSMAX), .HIB_CYC(HIB),
    .SHD_CYC(SHD), .RESTORE_CYC(RCYC)) dut_u (.mclk, .rst, .chip_reset_n,
    .boot_option_pins, .hibernate_request_n, .host_cmd, .activity, .long_sleep_en,
    .sleep_cycles, .restore_mode, .hib_enter, .shut_enter, .main_power_ok,
    .restore_pending_nv, .nvm_req, .nvm_factory_sel, .nvm_grant, .nvm_refused,
    .restore_pending_set, .restore_params, .restore_image, .logic_power_on,
    .context_retain, .rtc_run, .rtc_count, .ready, .state);
  lpm_host host_u (.mclk, .chip_reset_n, .boot_option_pins, .hibernate_request_n);

  // ==========
  // Clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ==========
  // Common tasks
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask
  // Bounded wait for a state; running out ends the run
  task automatic wait_st(input logic [7:0] st, input int bound);
    int i;
    i = 0;
    while (state !== st) begin
      @(negedge mclk);
      i++;
      if (i > bound) begin
        errors++;
        $display("unexpected state: expected %0h, seen %0h", st, state);
        end_of_test();
      end
    end
  endtask
  // Counts cycles spent in a state; running out ends the run
  task automatic dwell(input logic [7:0] st, output int n);
    n = 0;
    while (state === st) begin
      @(negedge mclk);
      n++;
      if (n > 2000) begin
        errors++;
        $display("unexpected dwell: expected at most %0d, seen %0d", 2000, n);
        end_of_test();
      end
    end
  endtask

  // ==========
  // Scenarios
  task automatic t_restore(input lpm_rmode_t m, input logic [2:0] code);
    int n;
    restore_mode       = m;
    restore_pending_nv = (code != 3'h6);
    host_u.boot(code);
    wait_st(LPM_RESTORE, 8);
    restore_pending_nv = 1'b0;
    check("pending set", 1, restore_pending_set);
    check("params", m != 2'h0, restore_params);
    check("image", m == 2'h2, restore_image);
    dwell(LPM_RESTORE, n);
    check("restore length", RCYC, n);
    check("state", LPM_RUN, state);
    check("pending clear", 0, restore_pending_set);
    $display("restore mode %0d code %0h done", m, code);
  endtask
  task automatic t_normal();
    main_power_ok = 1'b0;
    host_u.boot(3'h0);
    repeat (4) @(negedge mclk);
    check("boot without power", LPM_BOOT, state);
    main_power_ok = 1'b1;
    for (int c = 0; c < 8; c++) begin
      if (c != 6) begin
        host_u.boot(c[2:0]);
        wait_st(LPM_RUN, 8);
        check("no restore", 0, restore_pending_set);
      end
    end
    nvm_req         = 1'b1;
    nvm_factory_sel = 1'b1;
    #1 check("refused", 1, nvm_refused);
    check("granted", 0, nvm_grant);
    @(negedge mclk);
    nvm_factory_sel = 1'b0;
    #1 check("granted", 1, nvm_grant);
    @(negedge mclk);
    nvm_req = 1'b0;
    $display("normal boot and sector access done");
  endtask
  task automatic t_sleep();
    int n;
    long_sleep_en = 1'b1;
    sleep_cycles  = 32'd40;
    activity      = 1'b0;
    wait_st(LPM_DSLEEP, IDLE + 4);
    check("retain", 1, context_retain);
    check("ready", 0, ready);
    host_cmd = 1'b1;
    @(negedge mclk);
    host_cmd = 1'b0;
    wait_st(LPM_DSWAKE, 2);
    dwell(LPM_DSWAKE, n);
    check("sleep wake", DSW, n);
    check("state", LPM_RUN, state);
    sleep_cycles = 32'd100;
    wait_st(LPM_DSLEEP, IDLE + 4);
    dwell(LPM_DSLEEP, n);
    check("long sleep", DSMAX, n);
    activity = 1'b1;
    wait_st(LPM_RUN, DSW + 2);
    long_sleep_en = 1'b0;
    activity      = 1'b0;
    wait_st(LPM_DSLEEP, IDLE + 4);
    dwell(LPM_DSLEEP, n);
    check("short sleep", DSMAX / 22, n);
    activity = 1'b1;
    wait_st(LPM_RUN, DSW + 2);
    $display("deep sleep done");
  endtask
  task automatic t_lowpwr(input logic shut);
    int n;
    logic [31:0] t;
    hib_enter  = 1'b1;
    shut_enter = shut;
    wait_st(shut ? LPM_SHUT : LPM_HIB, 4);
    hib_enter  = 1'b0;
    shut_enter = 1'b0;
    check("logic power", 0, logic_power_on);
    check("rtc run", !shut, rtc_run);
    t = rtc_count;
    nvm_req = 1'b1;
    repeat (3) @(negedge mclk);
    check("rtc count", shut ? 32'h0 : t + 3, rtc_count);
    check("granted", 0, nvm_grant);
    nvm_req = 1'b0;
    fork
      host_u.hib_wake();
    join_none
    wait_st(LPM_WAKE, 6);
    dwell(LPM_WAKE, n);
    check("wake length", shut ? SHD : HIB, n);
    check("state", LPM_RUN, state);
    $display("low power shut=%0d done", shut);
  endtask

  // ==========
  // Main sequence
  initial begin
    rst = 1'b1;
    host_cmd = 1'b0;
    activity = 1'b1;
    long_sleep_en = 1'b0;
    sleep_cycles = 32'd1;
    restore_mode = 2'h0;
    hib_enter = 1'b0;
    shut_enter = 1'b0;
    main_power_ok = 1'b1;
    restore_pending_nv = 1'b0;
    nvm_req = 1'b0;
    nvm_factory_sel = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    for (int m = 0; m < 3; m++) t_restore(lpm_rmode_t'(m), 3'h6);
    t_restore(2'h1, 3'h0);
    t_normal();
    t_sleep();
    t_lowpwr(1'b0);
    t_lowpwr(1'b1);
    end_of_test();
  end
endmodule
